// ===== src/ccb_pkg.sv
// Notes on behaviour
// - B4h compares accumulator, immediate; branch, three bytes
// - B8h-BFh compare working register, immediate; branch
// - B6h/B7h compare indirect RAM byte, immediate; branch
// - Compare: counter plus three, then add displacement if operands differ
// - Carry set if operand below immediate, else cleared
// - Unsigned compare; neither operand is modified
// - Displacement is signed, added after advancing
// - E4h clears accumulator, flags untouched
// - C3h clears carry; C2h clears addressed bit
// - F4h inverts accumulator, flags untouched
// - B3h inverts carry; B2h inverts addressed bit
// - Port bit complement reads output latch, not pin
// - Low nibble above nine or aux: add six
// - Then carry or high above nine: add sixty
// - D4h decimal adjust adds 00h/06h/60h/66h
// - Decimal adjust keeps overflow; carry only sets
package ccb_pkg;

    typedef enum logic [0:0] {
        CCB_IDLE = 1'b0,
        CCB_COMMIT = 1'b1
    } ccb_state_type;

    // Opcode encodings
    localparam logic [7:0] OP_CMP_ACC = 8'hB4;
    localparam logic [4:0] OP_CMP_REG_HI = 5'h17;
    localparam logic [6:0] OP_CMP_IND_HI = 7'h5B;
    localparam logic [7:0] OP_CLEAR_ACC = 8'hE4;
    localparam logic [7:0] OP_CLEAR_CARRY = 8'hC3;
    localparam logic [7:0] OP_CLEAR_BIT = 8'hC2;
    localparam logic [7:0] OP_INV_ACC = 8'hF4;
    localparam logic [7:0] OP_INV_CARRY = 8'hB3;
    localparam logic [7:0] OP_INV_BIT = 8'hB2;
    localparam logic [7:0] OP_BCD_ADJ = 8'hD4;

    // Instruction lengths in bytes
    localparam logic [15:0] LEN_CMP = 16'h0003;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_ONE = 16'h0001;

    // Decimal adjust constants
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    // Port bit space: addresses 80h-87h, 90h-97h, A0h-A7h, B0h-B7h
    localparam logic [1:0] PORT_BIT_TOP = 2'h2;

    // Reset values
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [15:0] COUNTER_RESET = 16'h0000;
    localparam logic CARRY_RESET = 1'b0;

endpackage

// ===== src/ccb_exec.sv
module ccb_exec (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic exec_valid,
    input wire logic [7:0] exec_opcode,
    input wire logic [7:0] exec_byte2,
    input wire logic [7:0] exec_byte3,
    input wire logic [7:0] operand_data,
    input wire logic aux_carry_flag,
    input wire logic bit_latch_value,
    input wire logic bit_pin_value,
    input wire logic acc_load_en,
    input wire logic [7:0] acc_load_data,
    input wire logic carry_load_en,
    input wire logic carry_load_data,
    input wire logic counter_load_en,
    input wire logic [15:0] counter_load_data,
    output logic exec_busy,
    output logic exec_done,
    output logic exec_unknown,
    output logic [7:0] acc_out,
    output logic carry_flag,
    output logic [15:0] program_counter,
    output logic [2:0] operand_sel,
    output logic operand_indirect,
    output logic bit_wr_en,
    output logic [7:0] bit_wr_addr,
    output logic bit_wr_data
);

    ccb_pkg::ccb_state_type state_reg, state_next;
    logic [7:0] acc_reg, acc_next;
    logic carry_reg, carry_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] cmp_count_reg;
    logic cmp_carry_reg;
    logic done_reg, unknown_reg;
    logic [2:0] sel_reg;
    logic ind_reg;
    logic bit_en_reg, bit_data_reg;
    logic [7:0] bit_addr_reg;

    // Decode; a request is only taken while no compare is committing
    wire accept = exec_valid && (state_reg == ccb_pkg::CCB_IDLE);
    wire is_cmp_acc = exec_opcode == ccb_pkg::OP_CMP_ACC;
    wire is_cmp_reg = exec_opcode[7:3] == ccb_pkg::OP_CMP_REG_HI;
    wire is_cmp_ind = exec_opcode[7:1] == ccb_pkg::OP_CMP_IND_HI;
    wire is_cmp = is_cmp_acc || is_cmp_reg || is_cmp_ind;
    wire is_clear_acc = exec_opcode == ccb_pkg::OP_CLEAR_ACC;
    wire is_clear_carry = exec_opcode == ccb_pkg::OP_CLEAR_CARRY;
    wire is_clear_bit = exec_opcode == ccb_pkg::OP_CLEAR_BIT;
    wire is_inv_acc = exec_opcode == ccb_pkg::OP_INV_ACC;
    wire is_inv_carry = exec_opcode == ccb_pkg::OP_INV_CARRY;
    wire is_inv_bit = exec_opcode == ccb_pkg::OP_INV_BIT;
    wire is_bcd_adj = exec_opcode == ccb_pkg::OP_BCD_ADJ;
    wire is_bit_op = is_clear_bit || is_inv_bit;
    wire is_known = is_cmp || is_clear_acc || is_clear_carry || is_bit_op
        || is_inv_acc || is_inv_carry || is_bcd_adj;

    // Compare: unsigned magnitude, operands only read
    wire [7:0] cmp_operand = is_cmp_acc ? acc_reg : operand_data;
    wire cmp_lt = cmp_operand < exec_byte2;
    wire cmp_ne = cmp_operand != exec_byte2;
    wire [15:0] count_plus3 = count_reg + ccb_pkg::LEN_CMP;
    wire [15:0] rel_sext = {{8{exec_byte3[7]}}, exec_byte3};
    wire [15:0] branch_target = count_plus3 + rel_sext;
    wire [15:0] cmp_count = cmp_ne ? branch_target : count_plus3;

    // Decimal adjust, low nibble then high nibble, carry may only set
    wire bcd_low_fix = (acc_reg[3:0] > ccb_pkg::BCD_MAX_DIGIT)
        || aux_carry_flag;
    wire [8:0] bcd_sum1 = {1'b0, acc_reg}
        + {5'h00, (bcd_low_fix ? ccb_pkg::BCD_FIX : 4'h0)};
    wire bcd_c1 = carry_reg || bcd_sum1[8];
    wire bcd_high_fix = bcd_c1
        || (bcd_sum1[7:4] > ccb_pkg::BCD_MAX_DIGIT);
    wire [4:0] bcd_sum2 = {1'b0, bcd_sum1[7:4]}
        + {1'b0, (bcd_high_fix ? ccb_pkg::BCD_FIX : 4'h0)};
    wire bcd_carry = bcd_c1 || bcd_sum2[4];
    wire [7:0] bcd_result = {bcd_sum2[3:0], bcd_sum1[3:0]};

    // Bit source: port bits come from the output latch so a pin
    // pulled low externally is not written back as a zero
    wire bit_is_port = (exec_byte2[7:6] == ccb_pkg::PORT_BIT_TOP)
        && !exec_byte2[3];
    wire bit_orig = bit_is_port ? bit_latch_value : bit_pin_value;
    wire bit_new = is_inv_bit ? !bit_orig : 1'b0;

    // Length of the non-compare instructions
    wire [15:0] op_len = is_bit_op ? ccb_pkg::LEN_TWO : ccb_pkg::LEN_ONE;

    // Next values; an accepted instruction outranks the load ports
    assign state_next = (accept && is_cmp) ? ccb_pkg::CCB_COMMIT
        : ccb_pkg::CCB_IDLE;
    assign acc_next = (accept && is_clear_acc) ? 8'h00
        : (accept && is_inv_acc) ? ~acc_reg
        : (accept && is_bcd_adj) ? bcd_result
        : acc_load_en ? acc_load_data : acc_reg;
    assign carry_next = (state_reg == ccb_pkg::CCB_COMMIT) ? cmp_carry_reg
        : (accept && is_clear_carry) ? 1'b0
        : (accept && is_inv_carry) ? !carry_reg
        : (accept && is_bcd_adj) ? bcd_carry
        : carry_load_en ? carry_load_data : carry_reg;
    assign count_next = (state_reg == ccb_pkg::CCB_COMMIT) ? cmp_count_reg
        : (accept && is_known && !is_cmp) ? count_reg + op_len
        : counter_load_en ? counter_load_data : count_reg;

    // Architectural state
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ccb_pkg::CCB_IDLE;
            acc_reg <= ccb_pkg::ACC_RESET;
            carry_reg <= ccb_pkg::CARRY_RESET;
            count_reg <= ccb_pkg::COUNTER_RESET;
        end
        else
        begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            count_reg <= count_next;
        end
    end

    // Compare results held for the second machine cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmp_count_reg <= ccb_pkg::COUNTER_RESET;
            cmp_carry_reg <= ccb_pkg::CARRY_RESET;
        end
        else if (accept && is_cmp)
        begin
            cmp_count_reg <= cmp_count;
            cmp_carry_reg <= cmp_lt;
        end
    end

    // Status and side outputs
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done_reg <= 1'b0;
            unknown_reg <= 1'b0;
            sel_reg <= 3'h0;
            ind_reg <= 1'b0;
            bit_en_reg <= 1'b0;
            bit_addr_reg <= 8'h00;
            bit_data_reg <= 1'b0;
        end
        else
        begin
            done_reg <= (state_reg == ccb_pkg::CCB_COMMIT)
                || (accept && !is_cmp);
            unknown_reg <= accept && !is_known;
            bit_en_reg <= accept && is_bit_op;
            if (accept && is_cmp)
            begin
                sel_reg <= exec_opcode[2:0];
                ind_reg <= is_cmp_ind;
            end
            if (accept && is_bit_op)
            begin
                bit_addr_reg <= exec_byte2;
                bit_data_reg <= bit_new;
            end
        end
    end

    assign exec_busy = state_reg == ccb_pkg::CCB_COMMIT;
    assign exec_done = done_reg;
    assign exec_unknown = unknown_reg;
    assign acc_out = acc_reg;
    assign carry_flag = carry_reg;
    assign program_counter = count_reg;
    assign operand_sel = sel_reg;
    assign operand_indirect = ind_reg;
    assign bit_wr_en = bit_en_reg;
    assign bit_wr_addr = bit_addr_reg;
    assign bit_wr_data = bit_data_reg;

    // Checks on the instruction group
    cmp_fall_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_cmp && !cmp_ne |-> ##2
        count_reg == $past(count_reg, 2) + ccb_pkg::LEN_CMP)
        else $error("compare fall-through counter wrong");
    cmp_branch_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_cmp && cmp_ne |-> ##2
        count_reg == $past(branch_target, 2))
        else $error("compare branch target wrong");
    cmp_carry_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_cmp |-> ##2 carry_reg == $past(cmp_lt, 2))
        else $error("compare carry wrong");
    cmp_keep_acc_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_cmp && !acc_load_en |=> acc_reg == $past(acc_reg))
        else $error("compare altered accumulator");
    // A carry load in the same cycle is a separate writer, not a flag change
    clear_acc_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_clear_acc && !carry_load_en |=> acc_reg == 8'h00
        && carry_reg == $past(carry_reg))
        else $error("clear accumulator wrong");
    inv_acc_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_inv_acc |=> acc_reg == ~$past(acc_reg))
        else $error("complement accumulator wrong");
    clear_carry_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_clear_carry |=> !carry_reg)
        else $error("clear carry wrong");
    port_latch_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_inv_bit && bit_is_port |=> bit_wr_en
        && bit_wr_data == !$past(bit_latch_value))
        else $error("port bit complement not from latch");
    adj_sticky_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_bcd_adj && carry_reg |=> carry_reg)
        else $error("decimal adjust cleared carry");
    adj_addend_a: assert property (@(posedge clk)
        disable iff (!reset_n)
        accept && is_bcd_adj |=> (acc_reg - $past(acc_reg)) inside
        {8'h00, 8'h06, 8'h60, 8'h66})
        else $error("decimal adjust addend wrong");

endmodule

// ===== verification/ccb_exec_tb.sv
module ccb_exec_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic exec_valid = 1'b0;
    logic [7:0] exec_opcode = 8'h00;
    logic [7:0] exec_byte2 = 8'h00;
    logic [7:0] exec_byte3 = 8'h00;
    logic [7:0] operand_data = 8'h00;
    logic aux_carry_flag = 1'b0;
    logic bit_latch_value = 1'b0;
    logic bit_pin_value = 1'b1;
    logic acc_load_en = 1'b0;
    logic [7:0] acc_load_data = 8'h00;
    logic carry_load_en = 1'b0;
    logic carry_load_data = 1'b0;
    logic counter_load_en = 1'b0;
    logic [15:0] counter_load_data = 16'h0000;
    logic exec_busy, exec_done, exec_unknown, carry_flag, operand_indirect;
    logic bit_wr_en, bit_wr_data, busy_seen, wr_seen, unk_seen;
    logic [7:0] acc_out, bit_wr_addr;
    logic [15:0] program_counter, epc;
    logic [2:0] operand_sel;
    // Accumulator in, carry in, aux in, accumulator out, carry out
    logic [27:0] bcd_tab [6] = '{28'hBE00241, 28'h56015C0, 28'h0010601,
        28'h9A00001, 28'h2900290, 28'hFA00601};
    // Opcode, bit address, expected written bit
    logic [23:0] bit_tab [3] = '{24'hB29101, 24'hB22000, 24'hC29500};
    int failures = 0;
    int checked = 0;
    int cycles = 0;
    int lat;

    ccb_exec uut (.clk, .reset_n, .exec_valid, .exec_opcode, .exec_byte2,
        .exec_byte3, .operand_data, .aux_carry_flag, .bit_latch_value,
        .bit_pin_value, .acc_load_en, .acc_load_data, .carry_load_en,
        .carry_load_data, .counter_load_en, .counter_load_data,
        .exec_busy, .exec_done, .exec_unknown, .acc_out, .carry_flag,
        .program_counter, .operand_sel, .operand_indirect, .bit_wr_en,
        .bit_wr_addr, .bit_wr_data);

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Whole sequence needs under a hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            summarize();
        end
    end

    // Preset state through the load ports for one cycle
    task automatic load(logic [7:0] a, logic c, logic [15:0] p);
        acc_load_en = 1'b1;
        acc_load_data = a;
        carry_load_en = 1'b1;
        carry_load_data = c;
        counter_load_en = 1'b1;
        counter_load_data = p;
        @(posedge clk);
        #1;
        acc_load_en = 1'b0;
        carry_load_en = 1'b0;
        counter_load_en = 1'b0;
        epc = p;
    endtask

    // One instruction; clash leaves a stray request up in the busy cycle
    task automatic run(logic [7:0] op, d2, d3, od, logic clash = 1'b0);
        exec_valid = 1'b1;
        exec_opcode = op;
        exec_byte2 = d2;
        exec_byte3 = d3;
        operand_data = od;
        @(posedge clk);
        #1;
        exec_valid = clash;
        if (clash)
            exec_opcode = 8'hE4;
        busy_seen = exec_busy;
        lat = 1;
        while (exec_done !== 1'b1 && lat < 5)
        begin
            @(posedge clk);
            #1;
            exec_valid = 1'b0;
            lat++;
        end
        wr_seen = bit_wr_en;
        unk_seen = exec_unknown;
        @(posedge clk);
        #1;
    endtask

    task automatic st(logic [7:0] a, logic c, int n);
        chk("latency", lat, n);
        chk("acc", acc_out, a);
        chk("carry", carry_flag, c);
        chk("pc", program_counter, epc);
    endtask

    // Main sequence; stray request during busy must not clear the acc
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk("reset", {exec_busy, carry_flag, acc_out}, 16'h0000);
        chk("reset_pc", program_counter, 16'h0000);
        load(8'h34, 1'b0, 16'h0100);
        run(8'hB4, 8'h60, 8'h10, 8'h00);
        epc = 16'h0113;
        st(8'h34, 1'b1, 2);
        chk("busy", busy_seen, 1'b1);
        run(8'hB4, 8'h34, 8'hF0, 8'h00, 1'b1);
        epc = 16'h0116;
        st(8'h34, 1'b0, 2);
        run(8'hB4, 8'h20, 8'hF0, 8'h00);
        epc = 16'h0109;
        st(8'h34, 1'b0, 2);
        for (int r = 0; r < 8; r++)
        begin
            run(8'hB8 | 8'(r), 8'h40, 8'h02, 8'(r * 16));
            epc += (r == 4) ? 16'h0003 : 16'h0005;
            st(8'h34, r < 4, 2);
            chk("sel", {operand_indirect, operand_sel}, 4'(r));
        end
        run(8'hB6, 8'h80, 8'h04, 8'h7F);
        epc += 16'h0007;
        st(8'h34, 1'b1, 2);
        chk("ind", {operand_indirect, operand_sel}, 4'hE);
        run(8'hB7, 8'h80, 8'h04, 8'h80);
        epc += 16'h0003;
        st(8'h34, 1'b0, 2);
        chk("ind", {operand_indirect, operand_sel}, 4'hF);
        load(8'h5C, 1'b1, 16'h0200);
        run(8'hE4, 8'h00, 8'h00, 8'h00);
        epc += 16'h0001;
        st(8'h00, 1'b1, 1);
        run(8'hF4, 8'h00, 8'h00, 8'h00);
        epc += 16'h0001;
        st(8'hFF, 1'b1, 1);
        run(8'hC3, 8'h00, 8'h00, 8'h00);
        epc += 16'h0001;
        st(8'hFF, 1'b0, 1);
        run(8'hB3, 8'h00, 8'h00, 8'h00);
        epc += 16'h0001;
        st(8'hFF, 1'b1, 1);
        // Latch and pin differ, so a wrong source shows in the data
        foreach (bit_tab[i])
        begin
            run(bit_tab[i][23:16], bit_tab[i][15:8], 8'h00, 8'h00);
            epc += 16'h0002;
            st(8'hFF, 1'b1, 1);
            chk("bit_wr", {wr_seen, bit_wr_data, bit_wr_addr},
                {1'b1, bit_tab[i][0], bit_tab[i][15:8]});
        end
        foreach (bcd_tab[i])
        begin
            load(bcd_tab[i][27:20], bcd_tab[i][16], epc);
            aux_carry_flag = bcd_tab[i][12];
            run(8'hD4, 8'h00, 8'h00, 8'h00);
            epc += 16'h0001;
            st(bcd_tab[i][11:4], bcd_tab[i][0], 1);
        end
        // Opcode outside the group must leave all state alone
        run(8'hA5, 8'h00, 8'h00, 8'h00);
        st(8'h60, 1'b1, 1);
        chk("unknown", unk_seen, 1'b1);
        summarize();
    end
endmodule
